// ### iocd_pkg.sv
/*
 * iocd_pkg: register map, reset values, mode codes and carrier types of the
 * input open circuit detector.
 * assumes: eight channels of 16-bit codes, 7-bit register addresses, 8-bit data.
 */
package iocd_pkg;

    localparam int unsigned NUM_CHAN   = 8;
    localparam int unsigned CODE_W     = 16;
    localparam int unsigned ADDR_W     = 7;
    localparam int unsigned DATA_W     = 8;

    // register offsets
    localparam logic [ADDR_W-1:0] ADDR_PROBE_ENABLE_MASK = 7'h23;
    localparam logic [ADDR_W-1:0] ADDR_OPEN_INPUT_FLAGS  = 7'h24;
    localparam logic [ADDR_W-1:0] ADDR_DETECT_MODE_COUNT = 7'h2c;

    // values after reset
    localparam logic [DATA_W-1:0] RST_PROBE_ENABLE_MASK = 8'h00;
    localparam logic [DATA_W-1:0] RST_OPEN_INPUT_FLAGS  = 8'h00;
    localparam logic [DATA_W-1:0] RST_DETECT_MODE_COUNT = 8'h00;
    localparam logic [DATA_W-1:0] RST_RUN_COUNT         = 8'h00;

    // mode count codes
    localparam logic [DATA_W-1:0] MODE_DISABLED = 8'h00;
    localparam logic [DATA_W-1:0] MODE_MANUAL   = 8'h01;

    // software mode needs every oversampling select pin high
    localparam logic [2:0] OS_SOFTWARE = 3'h7;

    typedef enum logic [1:0] {
        ST_COUNT   = 2'b00,
        ST_SHIFT   = 2'b01,
        ST_RESTORE = 2'b10
    } iocd_state_type;

    typedef struct packed {
        logic                                valid;
        logic [NUM_CHAN-1:0][CODE_W-1:0]     code;
    } iocd_conv_type;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } iocd_reg_req_type;

endpackage

// ### iocd_code_hist.sv
/*
 * iocd_code_hist: keeps the last code of every channel and reports, one cycle
 * after each conversion, which channels changed against their previous code.
 * assumes: a conversion is presented as a one-cycle valid with all eight codes.
 */
`timescale 1ns/1ps
module iocd_code_hist
    import iocd_pkg::*;
(
    // clock and reset
    input  wire logic                CLOCK_I,
    input  wire logic                RSTN_I,
    // conversion in
    input  wire iocd_conv_type       conv_i,
    // change report
    output logic                     valid_o,
    output logic [NUM_CHAN-1:0]      changed_o
);

    logic [CODE_W-1:0]   mem_q [NUM_CHAN];
    logic                primed_q;
    logic                valid_q;
    logic [NUM_CHAN-1:0] changed_q;
    logic [NUM_CHAN-1:0] changed_d;

    genvar g;
    generate
        for (g = 0; g < NUM_CHAN; g++) begin : g_chan
            // no history yet counts as a change so the count never starts on junk
            assign changed_d[g] = !primed_q || (mem_q[g] != conv_i.code[g]);

            always_ff @(posedge CLOCK_I) begin
                if (conv_i.valid) begin
                    mem_q[g] <= conv_i.code[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            primed_q  <= 1'b0;
            valid_q   <= 1'b0;
            changed_q <= '0;
        end else begin
            valid_q <= conv_i.valid;
            if (conv_i.valid) begin
                primed_q  <= 1'b1;
                changed_q <= changed_d;
            end
        end
    end

    assign valid_o   = valid_q;
    assign changed_o = changed_q;

endmodule

// ### iocd_top.sv
/*
 * iocd_top: open input detector of an eight-channel simultaneous converter,
 * with its three registers on the device register port.
 * assumes: register port frames are already decoded into one-cycle read and
 * write strobes; conversion results arrive as a one-cycle valid pulse; the
 * analog front end takes CM_SHIFT_O as the per-channel raise of its common mode.
 */
`timescale 1ns/1ps

// Function
// - detection works only while the oversampling select pins place the part in software mode.
// - channels set to a unipolar single-ended range are never probed or flagged.
// - a mode count of 0x01 selects manual mode.
// - in manual mode each enable bit drives its channel's common-mode raise directly.
// - a mode count from 0x02 to 0xff selects automatic mode.
// - in automatic mode a probe starts after as many unchanged conversions as the mode count holds.
// - the automatic probe raises the common mode, checks the codes, then restores the common mode.
// - a channel whose code moves with the common-mode raise gets its open flag set.
// - in automatic mode the enable bits include or exclude each channel from probing and flagging.
module iocd_top
    import iocd_pkg::*;
(
    // clock and reset
    input  wire logic                CLOCK_I,
    input  wire logic                RSTN_I,
    // mode straps and range setup
    input  wire logic [2:0]          OVERSAMPLE_SELECT_PINS_I,
    input  wire logic [NUM_CHAN-1:0] CHAN_UNIPOLAR_I,
    // register port
    input  wire iocd_reg_req_type    REG_REQ_I,
    output logic [DATA_W-1:0]        REG_RDATA_O,
    output logic                     REG_RVALID_O,
    // conversion results
    input  wire iocd_conv_type       CONV_I,
    // front end control and status
    output logic [NUM_CHAN-1:0]      CM_SHIFT_O,
    output logic [NUM_CHAN-1:0]      CHAN_OPEN_FLAG_O,
    output logic                     PROBE_BUSY_O
);

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ref_a);
        hit = (a == ref_a);
    endfunction

    logic [DATA_W-1:0]   probe_enable_mask_q;
    logic [DATA_W-1:0]   open_input_flags_q;
    logic [DATA_W-1:0]   open_input_flags_d;
    logic [DATA_W-1:0]   detect_mode_count_q;
    logic [DATA_W-1:0]   run_count_q;
    logic [DATA_W-1:0]   run_count_d;
    logic [DATA_W-1:0]   rdata_q;
    logic                rvalid_q;
    logic [NUM_CHAN-1:0] cm_shift_q;
    logic [NUM_CHAN-1:0] cm_shift_d;
    iocd_state_type      state_q;
    iocd_state_type      state_d;

    wire                 software_mode;
    wire                 mode_manual;
    wire                 mode_auto;
    wire [NUM_CHAN-1:0]  eligible;
    wire [NUM_CHAN-1:0]  monitored;
    wire                 hist_valid;
    wire [NUM_CHAN-1:0]  hist_changed;
    wire                 any_change;
    wire                 wr_mask;
    wire                 wr_count;
    wire [DATA_W-1:0]    rdata_d;
    wire [DATA_W:0]      run_count_inc;

    assign software_mode = (OVERSAMPLE_SELECT_PINS_I == OS_SOFTWARE);
    assign mode_manual   = software_mode && (detect_mode_count_q == MODE_MANUAL);
    assign mode_auto     = software_mode && (detect_mode_count_q > MODE_MANUAL);
    assign eligible      = probe_enable_mask_q & ~CHAN_UNIPOLAR_I;
    assign monitored     = mode_auto ? eligible : '0;
    assign any_change    = |(hist_changed & monitored);
    assign run_count_inc = {1'b0, run_count_q} + 9'h001;

    // register writes only land in software mode; the hardware-mode part has no register port
    assign wr_mask  = REG_REQ_I.wr && software_mode && hit(REG_REQ_I.addr, ADDR_PROBE_ENABLE_MASK);
    assign wr_count = REG_REQ_I.wr && software_mode && hit(REG_REQ_I.addr, ADDR_DETECT_MODE_COUNT);

    assign rdata_d = hit(REG_REQ_I.addr, ADDR_PROBE_ENABLE_MASK) ? probe_enable_mask_q :
                     hit(REG_REQ_I.addr, ADDR_OPEN_INPUT_FLAGS)  ? open_input_flags_q  :
                     hit(REG_REQ_I.addr, ADDR_DETECT_MODE_COUNT) ? detect_mode_count_q :
                     8'h00;

    iocd_code_hist u_hist (
        .CLOCK_I   (CLOCK_I),
        .RSTN_I    (RSTN_I),
        .conv_i    (CONV_I),
        .valid_o   (hist_valid),
        .changed_o (hist_changed)
    );

    // automatic probe sequencer
    always_comb begin
        state_d            = state_q;
        run_count_d        = run_count_q;
        // a clear by a count write loses against a probe result landing in the same cycle
        open_input_flags_d = wr_count ? RST_OPEN_INPUT_FLAGS : open_input_flags_q;
        cm_shift_d         = '0;
        unique case (state_q)
            ST_COUNT: begin
                if (!mode_auto) begin
                    run_count_d = RST_RUN_COUNT;
                end else if (hist_valid) begin
                    if (any_change) begin
                        run_count_d = RST_RUN_COUNT;
                    end else if (run_count_inc >= {1'b0, detect_mode_count_q}) begin
                        run_count_d = RST_RUN_COUNT;
                        state_d     = ST_SHIFT;
                        cm_shift_d  = eligible;
                    end else begin
                        run_count_d = run_count_inc[DATA_W-1:0];
                    end
                end
            end
            ST_SHIFT: begin
                cm_shift_d = eligible;
                if (!mode_auto) begin
                    state_d    = ST_COUNT;
                    cm_shift_d = '0;
                end else if (hist_valid) begin
                    // each monitored channel's flag follows the latest probe result
                    open_input_flags_d = (open_input_flags_d & ~monitored) | (hist_changed & monitored);
                    state_d            = ST_RESTORE;
                    cm_shift_d         = '0;
                end
            end
            ST_RESTORE: begin
                // the conversion taken while the common mode settles back is discarded
                if (!mode_auto || hist_valid) begin
                    state_d = ST_COUNT;
                end
            end
            default: begin
                state_d = ST_COUNT;
            end
        endcase
        if (mode_manual) begin
            cm_shift_d = eligible;
        end
    end

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            probe_enable_mask_q <= RST_PROBE_ENABLE_MASK;
            detect_mode_count_q <= RST_DETECT_MODE_COUNT;
        end else begin
            if (wr_mask) begin
                probe_enable_mask_q <= REG_REQ_I.wdata;
            end
            if (wr_count) begin
                detect_mode_count_q <= REG_REQ_I.wdata;
            end
        end
    end

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state_q            <= ST_COUNT;
            run_count_q        <= RST_RUN_COUNT;
            open_input_flags_q <= RST_OPEN_INPUT_FLAGS;
            cm_shift_q         <= '0;
        end else begin
            state_q            <= state_d;
            run_count_q        <= run_count_d;
            open_input_flags_q <= open_input_flags_d;
            cm_shift_q         <= cm_shift_d;
        end
    end

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= REG_REQ_I.rd && software_mode;
            if (REG_REQ_I.rd && software_mode) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign REG_RDATA_O      = rdata_q;
    assign REG_RVALID_O     = rvalid_q;
    assign CM_SHIFT_O       = cm_shift_q;
    assign CHAN_OPEN_FLAG_O = open_input_flags_q;
    assign PROBE_BUSY_O     = (state_q != ST_COUNT);

endmodule

// ### iocd_assertions.sv
/* iocd_assertions: port-level checks of the open input detector.
   assumes: bound to iocd_top; mode and mask shadows follow accepted writes. */
`timescale 1ns/1ps
module iocd_assertions
    import iocd_pkg::*;
(
    // clock and reset
    input  wire logic                CLOCK_I,
    input  wire logic                RSTN_I,
    // inputs
    input  wire logic [2:0]          OVERSAMPLE_SELECT_PINS_I,
    input  wire logic [NUM_CHAN-1:0] CHAN_UNIPOLAR_I,
    input  wire iocd_reg_req_type    REG_REQ_I,
    input  wire iocd_conv_type       CONV_I,
    // outputs
    input  wire logic [DATA_W-1:0]   REG_RDATA_O,
    input  wire logic                REG_RVALID_O,
    input  wire logic [NUM_CHAN-1:0] CM_SHIFT_O,
    input  wire logic [NUM_CHAN-1:0] CHAN_OPEN_FLAG_O,
    input  wire logic                PROBE_BUSY_O
);
    logic [DATA_W-1:0] mode_q;
    logic [DATA_W-1:0] mask_q;
    wire sw      = OVERSAMPLE_SELECT_PINS_I == OS_SOFTWARE;
    wire wr_cnt  = sw && REG_REQ_I.wr && REG_REQ_I.addr == ADDR_DETECT_MODE_COUNT;
    wire wr_msk  = sw && REG_REQ_I.wr && REG_REQ_I.addr == ADDR_PROBE_ENABLE_MASK;
    wire is_man  = sw && mode_q == MODE_MANUAL;
    wire is_auto = sw && mode_q > MODE_MANUAL;
    wire is_off  = !sw || mode_q == MODE_DISABLED;

    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            mode_q <= RST_DETECT_MODE_COUNT;
            mask_q <= RST_PROBE_ENABLE_MASK;
        end else begin
            if (wr_cnt) mode_q <= REG_REQ_I.wdata;
            if (wr_msk) mask_q <= REG_REQ_I.wdata;
        end
    end

    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RSTN_I);

    a_rd_answer: assert property (REG_RVALID_O == $past(REG_REQ_I.rd && sw))
        else $error("read answer mismatch");
    a_rdata_hold: assert property (!REG_RVALID_O |-> $stable(REG_RDATA_O))
        else $error("read data moved without answer");
    a_unipolar_excl: assert property (((CM_SHIFT_O | CHAN_OPEN_FLAG_O) & CHAN_UNIPOLAR_I) == '0)
        else $error("unipolar channel shifted or flagged");
    a_manual_cm: assert property (is_man && $past(is_man) |-> CM_SHIFT_O == ($past(mask_q) & ~CHAN_UNIPOLAR_I))
        else $error("manual shift differs from mask");
    a_off_idle: assert property (is_off && $past(is_off) |-> CM_SHIFT_O == '0 && !PROBE_BUSY_O)
        else $error("shift or probe while detection off");
    a_shift_busy: assert property ((|CM_SHIFT_O) && is_auto && $past(is_auto) |-> PROBE_BUSY_O)
        else $error("automatic shift outside probe");
    a_probe_start: assert property ($rose(PROBE_BUSY_O) |-> $past(CONV_I.valid, 2))
        else $error("probe not launched by a conversion");
    a_flag_cause: assert property ($changed(CHAN_OPEN_FLAG_O) |-> $past(PROBE_BUSY_O) || $past(wr_cnt) || $past(wr_cnt, 2))
        else $error("open flags moved without probe");

    c_probe: cover property ($rose(PROBE_BUSY_O));
    c_flag: cover property ($rose(|CHAN_OPEN_FLAG_O));
    c_manual: cover property (is_man && |CM_SHIFT_O);
endmodule

bind iocd_top iocd_assertions u_iocd_assertions (
    .CLOCK_I(CLOCK_I), .RSTN_I(RSTN_I), .OVERSAMPLE_SELECT_PINS_I(OVERSAMPLE_SELECT_PINS_I),
    .CHAN_UNIPOLAR_I(CHAN_UNIPOLAR_I), .REG_REQ_I(REG_REQ_I), .CONV_I(CONV_I), .REG_RDATA_O(REG_RDATA_O),
    .REG_RVALID_O(REG_RVALID_O), .CM_SHIFT_O(CM_SHIFT_O), .CHAN_OPEN_FLAG_O(CHAN_OPEN_FLAG_O),
    .PROBE_BUSY_O(PROBE_BUSY_O)
);

// ### iocd_fe_model.sv
/* iocd_fe_model: converter front end; an open channel moves its code while
   its common mode is raised.
   assumes: start_i is a one-cycle request made after a falling edge. */
`timescale 1ns/1ps
module iocd_fe_model
    import iocd_pkg::*;
(
    // bench side
    input  wire logic                            clk_i,
    input  wire logic                            start_i,
    input  wire logic [NUM_CHAN-1:0][CODE_W-1:0] base_i,
    input  wire logic [NUM_CHAN-1:0]             open_i,
    // detector side
    input  wire logic [NUM_CHAN-1:0]             cm_i,
    output iocd_conv_type                        conv_o
);
    initial conv_o = '0;
    // idle codes toggle so a stale value is never taken for a result
    always @(posedge clk_i) begin
        conv_o.valid <= start_i;
        for (int n = 0; n < NUM_CHAN; n++) begin
            conv_o.code[n] <= start_i ? base_i[n] + ((open_i[n] && cm_i[n]) ? 16'h0100 : 16'h0000) : ~conv_o.code[n];
        end
    end
endmodule

// ### tb_input_open_circuit_detector.sv
/* tb_input_open_circuit_detector: self-checking bench of iocd_top.
   assumes: iocd_fe_model answers conversion requests. */
`timescale 1ns/1ps
module tb_input_open_circuit_detector import iocd_pkg::*;;
    logic                            clk = 1'b0, rstn = 1'b0, start = 1'b0, rvalid, busy;
    logic [2:0]                      pins = 3'h7;
    logic [NUM_CHAN-1:0]             uni = 8'h00, msk, opn, elig, cm, flags;
    logic [NUM_CHAN-1:0][CODE_W-1:0] base = '0;
    logic [DATA_W-1:0]               rdata, q[$], cnt_tab[3] = '{8'h02, 8'h06, 8'hff};
    iocd_reg_req_type                req = '0;
    iocd_conv_type                   conv;
    int                              err_total = 0, n_tests = 0, cyc = 0, seed = 4828;

    iocd_top u_iocd_top (.CLOCK_I(clk), .RSTN_I(rstn), .OVERSAMPLE_SELECT_PINS_I(pins), .CHAN_UNIPOLAR_I(uni),
        .REG_REQ_I(req), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .CONV_I(conv), .CM_SHIFT_O(cm),
        .CHAN_OPEN_FLAG_O(flags), .PROBE_BUSY_O(busy));
    iocd_fe_model u_iocd_fe_model (.clk_i(clk), .start_i(start), .base_i(base), .open_i(opn), .cm_i(cm),
        .conv_o(conv));

    initial forever #2.5 clk = ~clk;

    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict;
        if (err_total == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wr(logic [6:0] a, logic [7:0] d);
        @(negedge clk);
        req = {1'b1, 1'b0, a, d};
        @(negedge clk);
        req = '0;
    endtask
    // a read in hardware mode gets no answer, so nothing is noted
    task automatic rd(logic [6:0] a, logic [7:0] e);
        @(negedge clk);
        req = {1'b0, 1'b1, a, 8'h00};
        if (pins == OS_SOFTWARE) q.push_back(e);
        @(negedge clk);
        req = '0;
    endtask
    task automatic cnv;
        @(negedge clk);
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    always @(negedge clk) begin
        if (rvalid === 1'b1) chk("rdata", q.size() ? q.pop_front() : 8'hxx, rdata);
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            print_verdict;
        end
    end

    initial begin
        uni = {4'($random(seed)), 4'h0};
        repeat (12) @(negedge clk);
        rstn = 1'b1;
        rd(ADDR_PROBE_ENABLE_MASK, RST_PROBE_ENABLE_MASK);
        rd(ADDR_DETECT_MODE_COUNT, RST_DETECT_MODE_COUNT);
        rd(7'h10, 8'h00);
        wr(ADDR_OPEN_INPUT_FLAGS, 8'hff);
        rd(ADDR_OPEN_INPUT_FLAGS, RST_OPEN_INPUT_FLAGS);
        msk = 8'($random(seed));
        wr(ADDR_PROBE_ENABLE_MASK, msk);
        rd(ADDR_PROBE_ENABLE_MASK, msk);
        wr(ADDR_DETECT_MODE_COUNT, MODE_MANUAL);
        repeat (2) @(negedge clk);
        chk("manual shift", msk & ~uni, cm);
        pins = 3'($random(seed)) & 3'h6;
        rd(ADDR_DETECT_MODE_COUNT, 8'h00);
        wr(ADDR_DETECT_MODE_COUNT, MODE_DISABLED);
        pins = OS_SOFTWARE;
        rd(ADDR_DETECT_MODE_COUNT, MODE_MANUAL);
        wr(ADDR_DETECT_MODE_COUNT, MODE_DISABLED);
        foreach (cnt_tab[i]) begin
            msk = 8'($random(seed)) | 8'h01;
            opn = 8'($random(seed));
            elig = msk & ~uni;
            base = {$random(seed), $random(seed), $random(seed), $random(seed)};
            wr(ADDR_PROBE_ENABLE_MASK, msk);
            wr(ADDR_DETECT_MODE_COUNT, cnt_tab[i]);
            rd(ADDR_OPEN_INPUT_FLAGS, 8'h00);
            repeat (cnt_tab[i]) cnv;
            base[0] = ~base[0];
            repeat (cnt_tab[i]) cnv;
            chk("early shift", 8'h00, cm);
            cnv;
            chk("probe shift", elig, cm);
            chk("probe busy", 8'h01, {7'h0, busy});
            cnv;
            chk("restored", 8'h00, cm);
            chk("flags", opn & elig, flags);
            rd(ADDR_OPEN_INPUT_FLAGS, opn & elig);
            cnv;
            chk("probe done", 8'h00, {7'h0, busy});
        end
        repeat (4) @(negedge clk);
        chk("unanswered reads", 8'h00, 8'(q.size()));
        print_verdict;
    end
endmodule
